// *** logic/fdwp_top.sv ***
// Overview of operation
// - Four byte registers at E10000..E10006: status/command, track, sector, data.
// - Controller accepts eleven commands from restore to force interrupt.
// - Sector read or write aborts on error; track read reports and continues.
// - Seek steps heads to the track register; step repeats last direction.
// - DMA address counts upward by one after each word written.
// - Enable rising edge raises one request writing the buffer before any byte.
// - Count register bit 15 reads as active-low underrun or overrun flag.
// - Transfer starts when the synced byte request is seen with DMA enabled and misc direction clear.
// - Byte request is resynchronised by a phase-one flip-flop before strobing.
// - Sequencer enters states one, two and three on successive phase-one edges.
// - Transfer and read strobes are active from state one until state three.
// - While read strobe is low, controller drives its byte and drops request.
// - First byte latches into the high byte at strobe end; toggle sets.
// - Second byte latches low; toggle clears and raises a genuine request.
// - Bus request is only raised while not at terminal count.
// - Request flip-flop asserts on the next phase-two edge after its input.
// - After grant the word is written at the DMA address counter.
module fdwp_top
  import fdwp_pkg::*;
#(
  parameter int SECTOR_BYTES = 512
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [23:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [15:0] cpu_wdata_i,
  output logic [15:0] cpu_rdata_o,
  input wire logic [7:0] disk_byte_i,
  input wire logic disk_byte_valid_i,
  input wire logic disk_error_i,
  input wire logic index_i,
  output logic step_o,
  output logic step_dir_o,
  output logic fdc_intr_o,
  output logic [7:0] disk_data_bus_o,
  output logic transfer_strobe_n_o,
  output logic fdc_read_strobe_n_o,
  output logic disk_bus_request_n_o,
  input wire logic bus_grant_i,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [15:0] mem_wdata_o
);

  function automatic logic hit(input logic [23:0] a, input logic [23:0] ofs);
    hit = (a == ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Phase clock enables and pin synchronisers.
  logic [3:0] pck_cnt_q, pck_cnt_d;
  logic [10:0] pin_meta_q, pin_sync_q;
  logic [1:0] pin_prev_q;
  logic phase_clock_one, phase_clock_two, byte_rise, index_rise;
  logic [7:0] in_byte;
  logic in_err;

  always_comb begin
    pck_cnt_d = (pck_cnt_q == PCK_LAST) ? 4'h0 : pck_cnt_q + 4'h1;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pck_cnt_q <= 4'h0;
      pin_meta_q <= 11'h000;
      pin_sync_q <= 11'h000;
      pin_prev_q <= 2'h0;
    end else begin
      pck_cnt_q <= pck_cnt_d;
      pin_meta_q <= {disk_error_i, index_i, disk_byte_valid_i, disk_byte_i};
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q[9:8];
    end
  end

  assign phase_clock_one = (pck_cnt_q == 4'h0);
  assign phase_clock_two = (pck_cnt_q == PCK_TWO_AT);
  assign in_byte = pin_sync_q[7:0];
  assign in_err = pin_sync_q[10];
  assign byte_rise = pin_sync_q[8] & ~pin_prev_q[0];
  assign index_rise = pin_sync_q[9] & ~pin_prev_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Floppy controller registers and command engine.
  fdwp_ctl_t ctl_q, ctl_d;
  fdwp_seq_t seq_q, seq_d;
  logic [7:0] track_q, track_d, sector_q, sector_d, data_q, data_d, head_q, head_d;
  logic [3:0] cmd_q, cmd_d;
  logic [15:0] bcnt_q, bcnt_d;
  logic busy_q, busy_d, err_q, err_d, lost_q, lost_d, irq_q, irq_d;
  logic fdc_byte_request_q, fdc_byte_request_d, dir_q, dir_d, step_q, step_d;
  logic [15:0] rdata_q, rdata_d;
  logic lost_event;
  logic [7:0] target;
  logic dma_en_q, dma_en_d, dma_dir_q, dma_dir_d, misc_dir_q, misc_dir_d;
  logic [COUNT_WIDTH-1:0] count_q, count_d;
  logic [15:0] dma_addr_q, dma_addr_d, buf_q, buf_d, maddr_q, maddr_d, mdata_q, mdata_d;
  logic toggle_q, toggle_d, pend_q, pend_d, req_n_q, req_n_d, underrun_q, underrun_d;
  logic byte_request_synced_q, byte_request_synced_d, mwe_q, mwe_d;

  always_comb begin
    ctl_d = ctl_q;
    track_d = track_q;
    sector_d = sector_q;
    data_d = data_q;
    head_d = head_q;
    cmd_d = cmd_q;
    bcnt_d = bcnt_q;
    busy_d = busy_q;
    err_d = err_q;
    lost_d = lost_q;
    irq_d = irq_q;
    dir_d = dir_q;
    step_d = 1'b0;
    fdc_byte_request_d = fdc_byte_request_q;
    lost_event = 1'b0;
    target = (cmd_q == CMD_RESTORE) ? 8'h00 : track_q;
    if (cpu_wr_i && hit(cpu_addr_i, FDC_TRACK_ADDR)) track_d = cpu_wdata_i[7:0];
    if (cpu_wr_i && hit(cpu_addr_i, FDC_SECTOR_ADDR)) sector_d = cpu_wdata_i[7:0];
    if (cpu_wr_i && hit(cpu_addr_i, FDC_DATA_ADDR)) data_d = cpu_wdata_i[7:0];
    if (cpu_rd_i && hit(cpu_addr_i, FDC_STATUS_CMD_ADDR)) irq_d = 1'b0;
    if (cpu_rd_i && hit(cpu_addr_i, FDC_DATA_ADDR)) fdc_byte_request_d = 1'b0;
    if (seq_q == SEQ_QB) fdc_byte_request_d = 1'b0;
    case (ctl_q)
      CTL_STEP: begin
        if (phase_clock_two) begin
          if (cmd_q == CMD_STEP || cmd_q == CMD_STEP_IN || cmd_q == CMD_STEP_OUT) begin
            step_d = 1'b1;
            head_d = dir_q ? head_q + 8'h01 : head_q - 8'h01;
            ctl_d = CTL_IDLE;
          end else if (head_q == target) begin
            ctl_d = CTL_IDLE;
          end else begin
            step_d = 1'b1;
            dir_d = (target > head_q);
            head_d = (target > head_q) ? head_q + 8'h01 : head_q - 8'h01;
          end
          if (ctl_d == CTL_IDLE) begin
            busy_d = 1'b0;
            irq_d = 1'b1;
          end
        end
      end
      CTL_XFER: begin
        if (byte_rise) begin
          if (cmd_q != CMD_WRITE_SECTOR && cmd_q != CMD_WRITE_FORMAT) data_d = in_byte;
          if (fdc_byte_request_q) begin
            lost_d = 1'b1;
            lost_event = 1'b1;
          end
          fdc_byte_request_d = 1'b1;
          bcnt_d = bcnt_q + 16'h0001;
          if (in_err) err_d = 1'b1;
          if ((in_err && cmd_q != CMD_READ_TRACK) ||
              (cmd_q == CMD_READ_ADDRESS && bcnt_q == 16'(ID_FIELD_BYTES - 1)) ||
              (cmd_q != CMD_READ_TRACK && bcnt_q == 16'(SECTOR_BYTES - 1))) begin
            ctl_d = CTL_IDLE;
          end
        end
        if (index_rise && cmd_q == CMD_READ_TRACK) ctl_d = CTL_IDLE;
        if (ctl_d == CTL_IDLE) begin
          busy_d = 1'b0;
          irq_d = 1'b1;
        end
      end
      default: begin
        ctl_d = CTL_IDLE;
      end
    endcase
    if (cpu_wr_i && hit(cpu_addr_i, FDC_STATUS_CMD_ADDR)) begin
      if (cpu_wdata_i[7:4] == CMD_FORCE_INTR) begin
        ctl_d = CTL_IDLE;
        busy_d = 1'b0;
        irq_d = 1'b1;
      end else if (!busy_q && cpu_wdata_i[7:4] < CMD_FORCE_INTR) begin
        cmd_d = cpu_wdata_i[7:4];
        busy_d = 1'b1;
        irq_d = 1'b0;
        err_d = 1'b0;
        lost_d = 1'b0;
        bcnt_d = 16'h0000;
        if (cpu_wdata_i[7:4] >= CMD_READ_SECTOR) begin
          ctl_d = CTL_XFER;
        end else begin
          ctl_d = CTL_STEP;
          if (cpu_wdata_i[7:4] == CMD_STEP_IN) dir_d = 1'b1;
          if (cpu_wdata_i[7:4] == CMD_STEP_OUT) dir_d = 1'b0;
        end
      end
    end
    if (cmd_q == CMD_RESTORE && ctl_q == CTL_STEP && ctl_d == CTL_IDLE) track_d = 8'h00;
    rdata_d = rdata_q;
    if (cpu_rd_i) begin
      rdata_d = 16'h0000;
      if (hit(cpu_addr_i, FDC_STATUS_CMD_ADDR)) begin
        rdata_d[ST_BUSY_POS] = busy_q;
        rdata_d[ST_BYTE_REQ_POS] = fdc_byte_request_q;
        rdata_d[ST_LOST_POS] = lost_q;
        rdata_d[ST_ERROR_POS] = err_q;
        rdata_d[ST_TRACK0_POS] = (head_q == 8'h00);
      end
      if (hit(cpu_addr_i, FDC_TRACK_ADDR)) rdata_d[7:0] = track_q;
      if (hit(cpu_addr_i, FDC_SECTOR_ADDR)) rdata_d[7:0] = sector_q;
      if (hit(cpu_addr_i, FDC_DATA_ADDR)) rdata_d[7:0] = data_q;
      if (hit(cpu_addr_i, DMA_COUNT_ADDR)) rdata_d = {~underrun_q, dma_dir_q, count_q};
      if (hit(cpu_addr_i, DMA_ADDRESS_ADDR)) rdata_d = dma_addr_q;
      if (hit(cpu_addr_i, MISC_CTRL_ADDR)) rdata_d[MISC_DIRECTION_POS] = misc_dir_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // DMA strobe sequencer, word packer and bus request.
  logic terminal, count_wr;

  assign terminal = (count_q == '0);
  assign count_wr = cpu_wr_i && hit(cpu_addr_i, DMA_COUNT_ADDR);

  always_comb begin
    seq_d = seq_q;
    dma_en_d = dma_en_q;
    dma_dir_d = dma_dir_q;
    misc_dir_d = misc_dir_q;
    count_d = count_q;
    dma_addr_d = dma_addr_q;
    buf_d = buf_q;
    toggle_d = toggle_q;
    pend_d = pend_q;
    req_n_d = req_n_q;
    underrun_d = underrun_q;
    maddr_d = maddr_q;
    mdata_d = mdata_q;
    mwe_d = 1'b0;
    byte_request_synced_d = byte_request_synced_q;
    // Grant is handled first so that a pair completing in the same cycle still requests.
    if (!req_n_q && bus_grant_i) begin
      mwe_d = 1'b1;
      maddr_d = dma_addr_q;
      mdata_d = buf_q;
      dma_addr_d = dma_addr_q + 16'h0001;
      count_d = count_q + 1'b1;
      req_n_d = 1'b1;
      pend_d = 1'b0;
    end
    if (phase_clock_one) begin
      byte_request_synced_d = fdc_byte_request_q;
      case (seq_q)
        SEQ_IDLE: begin
          if (byte_request_synced_q && dma_en_q && !misc_dir_q) seq_d = SEQ_QB;
        end
        SEQ_QB: begin
          seq_d = SEQ_QC;
        end
        SEQ_QC: begin
          seq_d = SEQ_QD;
          if (!toggle_q) begin
            buf_d[15:8] = data_q;
          end else begin
            buf_d[7:0] = data_q;
            if (count_d != '0) pend_d = 1'b1;
          end
          toggle_d = ~toggle_q;
        end
        default: begin
          seq_d = SEQ_IDLE;
        end
      endcase
    end
    if (phase_clock_two && pend_q && req_n_q) req_n_d = 1'b0;
    if (count_wr) begin
      underrun_d = 1'b0;
      dma_en_d = cpu_wdata_i[DMA_ENABLE_POS];
      dma_dir_d = cpu_wdata_i[DMA_DIRECTION_POS];
      count_d = cpu_wdata_i[COUNT_WIDTH-1:0];
      if (cpu_wdata_i[DMA_ENABLE_POS] && !dma_en_q && !misc_dir_q &&
          cpu_wdata_i[COUNT_WIDTH-1:0] != '0) pend_d = 1'b1;
    end
    if (lost_event) underrun_d = 1'b1;
    if (cpu_wr_i && hit(cpu_addr_i, DMA_ADDRESS_ADDR)) dma_addr_d = cpu_wdata_i;
    if (cpu_wr_i && hit(cpu_addr_i, MISC_CTRL_ADDR)) begin
      misc_dir_d = cpu_wdata_i[MISC_DIRECTION_POS];
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl_q <= CTL_IDLE;
      seq_q <= SEQ_IDLE;
      track_q <= FDC_REG_RESET;
      sector_q <= FDC_REG_RESET;
      data_q <= FDC_REG_RESET;
      head_q <= FDC_REG_RESET;
      cmd_q <= 4'h0;
      bcnt_q <= 16'h0000;
      {busy_q, err_q, lost_q, irq_q, dir_q, step_q} <= 6'h00;
      fdc_byte_request_q <= 1'b0;
      rdata_q <= 16'h0000;
      dma_en_q <= 1'b0;
      toggle_q <= 1'b0;
      pend_q <= 1'b0;
      req_n_q <= 1'b1;
      {dma_dir_q, misc_dir_q, underrun_q, byte_request_synced_q, mwe_q} <= 5'h00;
      count_q <= '0;
      dma_addr_q <= DMA_REG_RESET;
      buf_q <= DMA_REG_RESET;
      maddr_q <= DMA_REG_RESET;
      mdata_q <= DMA_REG_RESET;
    end else begin
      ctl_q <= ctl_d;
      seq_q <= seq_d;
      track_q <= track_d;
      sector_q <= sector_d;
      data_q <= data_d;
      head_q <= head_d;
      cmd_q <= cmd_d;
      bcnt_q <= bcnt_d;
      {busy_q, err_q, lost_q, irq_q, dir_q, step_q} <= {busy_d, err_d, lost_d, irq_d, dir_d, step_d};
      fdc_byte_request_q <= fdc_byte_request_d;
      rdata_q <= rdata_d;
      dma_en_q <= dma_en_d;
      toggle_q <= toggle_d;
      pend_q <= pend_d;
      req_n_q <= req_n_d;
      {dma_dir_q, misc_dir_q, underrun_q} <= {dma_dir_d, misc_dir_d, underrun_d};
      byte_request_synced_q <= byte_request_synced_d;
      mwe_q <= mwe_d;
      count_q <= count_d;
      dma_addr_q <= dma_addr_d;
      buf_q <= buf_d;
      maddr_q <= maddr_d;
      mdata_q <= mdata_d;
    end
  end

  assign cpu_rdata_o = rdata_q;
  assign step_o = step_q;
  assign step_dir_o = dir_q;
  assign fdc_intr_o = irq_q;
  assign transfer_strobe_n_o = ~(seq_q == SEQ_QB || seq_q == SEQ_QC);
  assign fdc_read_strobe_n_o = ~(seq_q == SEQ_QB || seq_q == SEQ_QC);
  assign disk_data_bus_o = fdc_read_strobe_n_o ? 8'h00 : data_q;
  assign disk_bus_request_n_o = req_n_q;
  assign mem_we_o = mwe_q;
  assign mem_addr_o = maddr_q;
  assign mem_wdata_o = mdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  a_strobe_width: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(transfer_strobe_n_o) |-> !transfer_strobe_n_o [*8] ##12 !transfer_strobe_n_o
      ##1 transfer_strobe_n_o)
    else $error("transfer strobe width wrong");
  a_seq_order: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (seq_q == SEQ_QB && phase_clock_one) |=> seq_q == SEQ_QC)
    else $error("sequencer skipped state two");
  a_req_drop: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (seq_q == SEQ_QB) |=> !fdc_byte_request_q || $past(byte_rise))
    else $error("byte request kept under read strobe");
  a_bus_on_strobe: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(fdc_read_strobe_n_o) |->
      ($past(toggle_q) ? buf_q[7:0] : buf_q[15:8]) == $past(disk_data_bus_o))
    else $error("byte driven under read strobe not latched");
  a_req_phase_two: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $fell(disk_bus_request_n_o) |-> $past(phase_clock_two) && $past(pend_q))
    else $error("bus request not on phase two");
  a_grant_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (!req_n_q && bus_grant_i) |=> mem_we_o && mem_addr_o == $past(dma_addr_q)
      && dma_addr_q == mem_addr_o + 16'h0001)
    else $error("word write or address step wrong");
  a_no_tc_req: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(pend_q) |-> !terminal || $past(count_wr))
    else $error("request raised at terminal count");
  a_false_xfer: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (count_wr && cpu_wdata_i[DMA_ENABLE_POS] && !dma_en_q && !misc_dir_q
      && cpu_wdata_i[COUNT_WIDTH-1:0] != '0) |=> ##[1:10] !disk_bus_request_n_o)
    else $error("enable edge gave no request");
  a_toggle_pair: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (seq_q == SEQ_QC && phase_clock_one && toggle_q) |=> !toggle_q && buf_q[7:0] == $past(data_q))
    else $error("second byte not packed low");
  a_flag_read: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cpu_rd_i && hit(cpu_addr_i, DMA_COUNT_ADDR)) |=> cpu_rdata_o[UNDERRUN_FLAG_POS] == !$past(underrun_q))
    else $error("underrun flag read wrong");
endmodule // fdwp_top

// *** logic/fdwp_pkg.sv ***
package fdwp_pkg;
  // Register byte addresses.
  localparam logic [23:0] FDC_STATUS_CMD_ADDR = 24'he10000;
  localparam logic [23:0] FDC_TRACK_ADDR = 24'he10002;
  localparam logic [23:0] FDC_SECTOR_ADDR = 24'he10004;
  localparam logic [23:0] FDC_DATA_ADDR = 24'he10006;
  localparam logic [23:0] DMA_COUNT_ADDR = 24'he40000;
  localparam logic [23:0] DMA_ADDRESS_ADDR = 24'he40002;
  localparam logic [23:0] MISC_CTRL_ADDR = 24'he40004;
  // Field positions.
  localparam int DMA_ENABLE_POS = 15;
  localparam int DMA_DIRECTION_POS = 14;
  localparam int UNDERRUN_FLAG_POS = 15;
  localparam int MISC_DIRECTION_POS = 14;
  localparam int COUNT_WIDTH = 14;
  localparam int ST_BUSY_POS = 0;
  localparam int ST_BYTE_REQ_POS = 1;
  localparam int ST_LOST_POS = 2;
  localparam int ST_ERROR_POS = 3;
  localparam int ST_TRACK0_POS = 6;
  // Values after reset.
  localparam logic [7:0] FDC_REG_RESET = 8'h00;
  localparam logic [15:0] DMA_REG_RESET = 16'h0000;
  // Command codes held in the upper nibble of a command byte.
  localparam logic [3:0] CMD_RESTORE = 4'h0;
  localparam logic [3:0] CMD_SEEK = 4'h1;
  localparam logic [3:0] CMD_STEP = 4'h2;
  localparam logic [3:0] CMD_STEP_IN = 4'h3;
  localparam logic [3:0] CMD_STEP_OUT = 4'h4;
  localparam logic [3:0] CMD_READ_SECTOR = 4'h5;
  localparam logic [3:0] CMD_WRITE_SECTOR = 4'h6;
  localparam logic [3:0] CMD_READ_ADDRESS = 4'h7;
  localparam logic [3:0] CMD_READ_TRACK = 4'h8;
  localparam logic [3:0] CMD_WRITE_FORMAT = 4'h9;
  localparam logic [3:0] CMD_FORCE_INTR = 4'ha;
  localparam int ID_FIELD_BYTES = 6;
  // Phase clock timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int PCK_PERIOD_NS = 100;
  localparam int PCK_DIV_CYC = PCK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [3:0] PCK_TWO_AT = 4'(PCK_DIV_CYC / 2);
  localparam logic [3:0] PCK_LAST = 4'(PCK_DIV_CYC - 1);
  localparam int STROBE_NS = 200;
  localparam int STROBE_CYC = STROBE_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'b0001,
    SEQ_QB = 4'b0010,
    SEQ_QC = 4'b0100,
    SEQ_QD = 4'b1000
  } fdwp_seq_t;

  typedef enum logic [2:0] {
    CTL_IDLE = 3'b001,
    CTL_STEP = 3'b010,
    CTL_XFER = 3'b100
  } fdwp_ctl_t;
endpackage

// *** test/fdwp_far_side.sv ***
// Drive pins and memory bus arbiter facing the packer.
module fdwp_far_side (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic spin_i,
  input wire logic err_i,
  input wire logic [3:0] grant_delay_i,
  input wire logic index_i,
  input wire logic disk_bus_request_n_i,
  output logic [7:0] disk_byte_o,
  output logic disk_byte_valid_o,
  output logic disk_error_o,
  output logic index_o,
  output logic bus_grant_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] slot_q;
  logic [7:0] next_q;
  logic [3:0] wait_q;

  assign index_o = index_i;

  ////////////////////////////////////////////////////////////////////////////////
  // Byte slots every 100 cycles while the disk spins; the line toggles between slots.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slot_q <= 7'h00;
      next_q <= 8'ha0;
      disk_byte_o <= 8'h5a;
      disk_byte_valid_o <= 1'b0;
      disk_error_o <= 1'b0;
    end else begin
      slot_q <= (spin_i && slot_q != 7'd99) ? slot_q + 7'h01 : 7'h00;
      disk_byte_valid_o <= spin_i && (slot_q == 7'd99 || (disk_byte_valid_o && slot_q < 7'd9));
      if (spin_i && slot_q == 7'd99) begin
        disk_byte_o <= next_q;
        next_q <= next_q + 8'h01;
        disk_error_o <= err_i;
      end else if (!disk_byte_valid_o) begin
        disk_byte_o <= ~disk_byte_o;
        disk_error_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One grant pulse per request after a chosen delay.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bus_grant_o <= 1'b0;
      wait_q <= 4'h0;
    end else if (bus_grant_o) begin
      bus_grant_o <= 1'b0;
      wait_q <= 4'h0;
    end else if (!disk_bus_request_n_i) begin
      if (wait_q == grant_delay_i) begin
        bus_grant_o <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end else begin
      wait_q <= 4'h0;
    end
  end
endmodule // fdwp_far_side

// *** test/tb_floppy_dma_word_packer.sv ***
module tb_floppy_dma_word_packer;
  import fdwp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [23:0] cpu_addr_i = 24'h000000;
  logic cpu_wr_i = 1'b0;
  logic cpu_rd_i = 1'b0;
  logic [15:0] cpu_wdata_i = 16'h0000;
  logic [15:0] cpu_rdata_o, mem_addr_o, mem_wdata_o;
  logic [7:0] disk_byte_i, disk_data_bus_o;
  logic disk_byte_valid_i, disk_error_i, index_i, step_o, step_dir_o, fdc_intr_o;
  logic transfer_strobe_n_o, fdc_read_strobe_n_o, disk_bus_request_n_o, bus_grant_i, mem_we_o;
  logic spin = 1'b0;
  logic err = 1'b0;
  logic [3:0] gdly = 4'h0;
  logic idx = 1'b0;
  logic [7:0] bus_seen = 8'h00;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int strobe_len = 0;
  int last_width = 0;
  logic [15:0] mem_a[$];
  logic [15:0] mem_d[$];

  always #5 clk_sys_i = ~clk_sys_i;

  fdwp_top #(.SECTOR_BYTES(4)) DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .cpu_addr_i(cpu_addr_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i),
    .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o), .disk_byte_i(disk_byte_i),
    .disk_byte_valid_i(disk_byte_valid_i), .disk_error_i(disk_error_i), .index_i(index_i),
    .step_o(step_o), .step_dir_o(step_dir_o), .fdc_intr_o(fdc_intr_o),
    .disk_data_bus_o(disk_data_bus_o), .transfer_strobe_n_o(transfer_strobe_n_o),
    .fdc_read_strobe_n_o(fdc_read_strobe_n_o), .disk_bus_request_n_o(disk_bus_request_n_o),
    .bus_grant_i(bus_grant_i), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o));

  fdwp_far_side far (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .spin_i(spin),
    .err_i(err), .grant_delay_i(gdly), .index_i(idx),
    .disk_bus_request_n_i(disk_bus_request_n_o),
    .disk_byte_o(disk_byte_i), .disk_byte_valid_o(disk_byte_valid_i),
    .disk_error_o(disk_error_i), .index_o(index_i), .bus_grant_o(bus_grant_i));

  ////////////////////////////////////////////////////////////////////////////////
  // Watchers for memory writes, strobe width and a hang.
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (mem_we_o === 1'b1) begin
      mem_a.push_back(mem_addr_o);
      mem_d.push_back(mem_wdata_o);
    end
    if (fdc_read_strobe_n_o === 1'b0) begin
      bus_seen <= disk_data_bus_o;
    end
    if (transfer_strobe_n_o === 1'b0) begin
      check({15'h0000, fdc_read_strobe_n_o}, 16'h0000);
      strobe_len <= strobe_len + 1;
    end else if (strobe_len != 0) begin
      last_width <= strobe_len;
      strobe_len <= 0;
    end
    if (cycles == 60000) begin
      failures++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    cpu_addr_i <= a;
    cpu_wdata_i <= d;
    cpu_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    cpu_wr_i <= 1'b0;
  endtask

  task automatic reg_rd(input logic [23:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    cpu_addr_i <= a;
    cpu_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    cpu_rd_i <= 1'b0;
    #1 d = cpu_rdata_o;
  endtask

  task automatic wait_for(input bit on_step, input int lim);
    int n;
    n = 0;
    while (n < lim && (on_step ? step_o : fdc_intr_o) !== 1'b1) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset_and_regs();
    logic [15:0] d;
    check({15'h0000, disk_bus_request_n_o}, 16'h0001);
    reg_rd(DMA_COUNT_ADDR, d);
    check(d, 16'h8000);
    reg_wr(FDC_TRACK_ADDR, 16'h0025);
    reg_wr(FDC_SECTOR_ADDR, 16'h0007);
    reg_wr(FDC_DATA_ADDR, 16'h00c3);
    reg_rd(FDC_TRACK_ADDR, d);
    check(d, 16'h0025);
    reg_rd(FDC_SECTOR_ADDR, d);
    check(d, 16'h0007);
    reg_rd(FDC_DATA_ADDR, d);
    check(d, 16'h00c3);
    reg_rd(24'he10008, d);
    check(d, 16'h0000);
  endtask

  task automatic t_commands();
    logic [15:0] d;
    for (int c = 0; c < 10; c++) begin
      reg_wr(FDC_STATUS_CMD_ADDR, {8'h00, 4'(c), 4'h0});
      reg_wr(FDC_STATUS_CMD_ADDR, {8'h00, CMD_FORCE_INTR, 4'h0});
      wait_for(1'b0, 60);
      check({15'h0000, fdc_intr_o}, 16'h0001);
      reg_rd(FDC_STATUS_CMD_ADDR, d);
      check({15'h0000, fdc_intr_o}, 16'h0000);
    end
  endtask

  task automatic t_step_dir();
    reg_wr(FDC_STATUS_CMD_ADDR, {8'h00, CMD_STEP_IN, 4'h0});
    wait_for(1'b1, 300);
    check({14'h0000, step_o, step_dir_o}, 16'h0003);
    wait_for(1'b0, 300);
    reg_wr(FDC_STATUS_CMD_ADDR, {8'h00, CMD_STEP_OUT, 4'h0});
    wait_for(1'b1, 300);
    check({14'h0000, step_o, step_dir_o}, 16'h0002);
    wait_for(1'b0, 300);
    reg_wr(FDC_STATUS_CMD_ADDR, {8'h00, CMD_STEP, 4'h0});
    wait_for(1'b1, 300);
    check({14'h0000, step_o, step_dir_o}, 16'h0002);
    wait_for(1'b0, 300);
  endtask

  task automatic t_false_transfer();
    logic [15:0] d;
    gdly <= 4'h6;
    reg_wr(DMA_ADDRESS_ADDR, 16'h0100);
    reg_wr(MISC_CTRL_ADDR, 16'h0000);
    reg_wr(DMA_COUNT_ADDR, 16'hbffe);
    repeat (60) @(posedge clk_sys_i);
    check(16'(mem_a.size()), 16'h0001);
    if (mem_a.size() > 0) check(mem_a.pop_front(), 16'h0100);
    void'(mem_d.pop_front());
    reg_rd(DMA_COUNT_ADDR, d);
    check(d, 16'hbfff);
  endtask

  task automatic t_sector_read();
    logic [15:0] d;
    gdly <= 4'h0;
    reg_wr(DMA_ADDRESS_ADDR, 16'h0200);
    reg_wr(DMA_COUNT_ADDR, 16'hbffe);
    reg_wr(FDC_SECTOR_ADDR, 16'h0001);
    reg_wr(FDC_STATUS_CMD_ADDR, {8'h00, CMD_READ_SECTOR, 4'h0});
    spin <= 1'b1;
    for (int i = 0; i < 2000 && mem_a.size() < 2; i++) @(posedge clk_sys_i);
    spin <= 1'b0;
    check(16'(last_width), 16'(STROBE_CYC));
    check({8'h00, bus_seen}, 16'h00a3);
    check(16'(mem_a.size()), 16'h0002);
    if (mem_a.size() == 2) begin
      check(mem_a[0], 16'h0200);
      check(mem_d[0], 16'ha0a1);
      check(mem_a[1], 16'h0201);
      check(mem_d[1], 16'ha2a3);
    end
    repeat (300) @(posedge clk_sys_i);
    check(16'(mem_a.size()), 16'h0002);
    reg_rd(DMA_COUNT_ADDR, d);
    check(d, 16'h8000);
  endtask

  task automatic t_track_read();
    logic [15:0] d;
    reg_wr(FDC_STATUS_CMD_ADDR, {8'h00, CMD_READ_TRACK, 4'h0});
    err <= 1'b1;
    spin <= 1'b1;
    repeat (480) @(posedge clk_sys_i);
    reg_rd(FDC_STATUS_CMD_ADDR, d);
    check(d & 16'h0009, 16'h0009);
    check(16'(mem_a.size()), 16'h0002);
    reg_wr(MISC_CTRL_ADDR, 16'h4000);
    repeat (250) @(posedge clk_sys_i);
    reg_rd(DMA_COUNT_ADDR, d);
    check(d, 16'h0000);
    idx <= 1'b1;
    wait_for(1'b0, 60);
    check({15'h0000, fdc_intr_o}, 16'h0001);
    idx <= 1'b0;
    err <= 1'b0;
    spin <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence.
  task automatic finish_test();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset_and_regs();
    t_commands();
    t_step_dir();
    t_false_transfer();
    t_sector_read();
    t_track_read();
    finish_test();
  end
endmodule // tb_floppy_dma_word_packer
